/* File: rtl/txdl_pkg.sv */
// package: shared constants and types for the transmit data-link buffer control
package txdl_pkg;

  // ****************************
  // register map
  // ****************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [11:0] ADDR_CTRL = 12'h150;
  localparam logic [11:0] ADDR_COUNT = 12'h154;
  localparam logic [11:0] ADDR_STATUS = 12'h158;
  localparam logic [3:0] PAGE_BUF0 = 4'h6;
  localparam logic [3:0] PAGE_BUF1 = 4'h7;

  // ****************************
  // field layout and resets
  // ****************************
  localparam int COUNT_W = 7;
  localparam int SEL_BIT = 7;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_FCS_BIT = 1;
  localparam int STAT_EOT_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_PEND0_BIT = 2;
  localparam int STAT_PEND1_BIT = 3;
  localparam int STAT_CUR_BIT = 4;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 7'h00;
  localparam int MEM_WORD_W = 6;

  // ****************************
  // link coding
  // ****************************
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [COUNT_W-1:0] REP_OCTETS = 7'h02;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [3:0] OCTET_BITS = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic en;
    logic [MEM_WORD_W-1:0] word;
    logic [31:0] data;
    logic [3:0] strb;
  } mem_wr_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPEN,
    ST_DATA,
    ST_FCS_LO,
    ST_FCS_HI,
    ST_CLOSE
  } tx_state_type;

endpackage : txdl_pkg

/* File: rtl/msg_store.sv */
// message store: two ping-pong transmit buffers, four octets per word
`timescale 1ns/1ps
module msg_store #(
  parameter int WORD_W = txdl_pkg::MEM_WORD_W
) (
  input wire logic aclk,
  input wire txdl_pkg::mem_wr_type wr,
  input wire logic [WORD_W-1:0] bus_word,
  output logic [31:0] bus_data,
  input wire logic [WORD_W+1:0] oct_addr,
  output logic [7:0] octet
);
  logic [31:0] mem [2**WORD_W];
  logic [31:0] oct_word;

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (wr.en && wr.strb[i]) begin
        mem[wr.word][8*i +: 8] <= wr.data[8*i +: 8];
      end
    end
  end

  assign bus_data = mem[bus_word];
  assign oct_word = mem[oct_addr[WORD_W+1:2]];
  assign octet = oct_word[8*oct_addr[1:0] +: 8];
endmodule : msg_store

/* File: rtl/check_gen.sv */
// frame check generator: bitwise reflected 16-bit check
`timescale 1ns/1ps
module check_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic bit_en,
  input wire logic bit_in,
  output logic [15:0] crc_nxt
);
  logic [15:0] crc_ff;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic [15:0] s;
    s = c >> 1;
    return (c[0] ^ b) ? (s ^ txdl_pkg::CRC_POLY) : s;
  endfunction : crc_step

  assign crc_nxt = clear ? txdl_pkg::CRC_INIT : (bit_en ? crc_step(crc_ff, bit_in) : crc_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_ff <= txdl_pkg::CRC_INIT;
    end else begin
      crc_ff <= crc_nxt;
    end
  end
endmodule : check_gen

/* File: rtl/tx_datalink_msg_buffer_count.sv */
// transmit data-link buffer select, count and serial message sender with register slave
//
// What this block does
// - Writing select bit queues buffer 0 or 1 for transmission on the link.
// - Reading select bit returns the next free buffer, 0 or 1.
// - While a buffer is unsent, the read bit points to the other buffer.
// - Bit-oriented: count is repetitions unless the other buffer is queued first; after the last, pulse end-of-transfer and stop.
// - Bit-oriented count of zero repeats until the other buffer is queued, with no end-of-transfer.
// - Message-oriented count is octet length including header, excluding check octets.
// - Mode bit 0 selects bit-oriented, 1 selects message-oriented transmission.
// - Message-oriented with check enabled appends computed check octets after the message.
`timescale 1ns/1ps
module tx_datalink_msg_buffer_count (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [txdl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [txdl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic dl_bit_req,
  output logic dl_bit,
  output logic dl_active,
  output logic tx_end_of_transfer
);
  localparam int CW = txdl_pkg::COUNT_W;
  localparam logic [CW-1:0] COUNT_ZERO = '0;
  localparam logic [CW-1:0] COUNT_RESET_C = txdl_pkg::COUNT_RESET;

  // ****************************
  // bus slave state
  // ****************************
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, wdata_ff;
  logic [3:0] wstrb_ff;
  logic [txdl_pkg::ADDR_W-1:0] awaddr_ff;

  // ****************************
  // control and transmit state
  // ****************************
  logic [CW-1:0] tx_msg_count_ff;
  logic message_oriented_mode_ff, tx_check_append_enable_ff, eot_sticky_ff;
  logic [1:0] pend_ff;
  logic cur_buf_ff, last_buf_ff;
  txdl_pkg::tx_state_type state_ff, nxt_state;
  logic run_msg_ff, run_fcs_ff;
  logic [CW-1:0] run_count_ff, idx_ff, rep_ff;
  logic [7:0] sh_ff, fcs_hi_ff;
  logic [3:0] bits_ff;
  logic [2:0] ones_ff;
  logic dl_bit_ff, dl_active_ff, eot_ff;

  // ****************************
  // register decode
  // ****************************
  function automatic logic is_buf(input logic [txdl_pkg::ADDR_W-1:0] a);
    return (a[11:8] == txdl_pkg::PAGE_BUF0) || (a[11:8] == txdl_pkg::PAGE_BUF1);
  endfunction : is_buf

  function automatic logic is_reg(input logic [txdl_pkg::ADDR_W-1:0] a);
    return (a == txdl_pkg::ADDR_CTRL) || (a == txdl_pkg::ADDR_COUNT) || (a == txdl_pkg::ADDR_STATUS);
  endfunction : is_reg

  wire aw_hs = awvalid && awready_ff;
  wire w_hs = wvalid && wready_ff;
  wire ar_hs = arvalid && arready_ff;
  wire wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_hit = wr_do && (is_reg(awaddr_ff) || is_buf(awaddr_ff));
  wire wr_count = wr_do && (awaddr_ff == txdl_pkg::ADDR_COUNT) && wstrb_ff[0];
  wire wr_ctrl = wr_do && (awaddr_ff == txdl_pkg::ADDR_CTRL) && wstrb_ff[0];
  wire wr_stat = wr_do && (awaddr_ff == txdl_pkg::ADDR_STATUS) && wstrb_ff[0];
  wire sel_wr_bit = wdata_ff[txdl_pkg::SEL_BIT];

  // free buffer as seen by software
  wire free_buf = (pend_ff == 2'b11) ? ~cur_buf_ff : pend_ff[0];

  txdl_pkg::mem_wr_type mem_wr;
  assign mem_wr.en = wr_do && is_buf(awaddr_ff);
  assign mem_wr.word = {awaddr_ff[8], awaddr_ff[6:2]};
  assign mem_wr.data = wdata_ff;
  assign mem_wr.strb = wstrb_ff;

  logic [31:0] mem_bus_data;
  logic [7:0] octet;
  logic fetch_buf;
  logic [CW-1:0] fetch_idx;
  wire [txdl_pkg::MEM_WORD_W+1:0] oct_addr = {fetch_buf, fetch_idx};

  msg_store #(.WORD_W(txdl_pkg::MEM_WORD_W)) u_store (
    .aclk(aclk),
    .wr(mem_wr),
    .bus_word({araddr[8], araddr[6:2]}),
    .bus_data(mem_bus_data),
    .oct_addr(oct_addr),
    .octet(octet)
  );

  wire [31:0] ctrl_rd = {30'h0, tx_check_append_enable_ff, message_oriented_mode_ff};
  wire [31:0] count_rd = {24'h0, free_buf, tx_msg_count_ff};
  wire [31:0] stat_rd = {27'h0, cur_buf_ff, pend_ff, (state_ff != txdl_pkg::ST_IDLE), eot_sticky_ff};
  wire [31:0] rd_mux = (araddr == txdl_pkg::ADDR_CTRL) ? ctrl_rd :
                       (araddr == txdl_pkg::ADDR_COUNT) ? count_rd :
                       (araddr == txdl_pkg::ADDR_STATUS) ? stat_rd :
                       is_buf(araddr) ? mem_bus_data : 32'h0;
  wire rd_hit = is_reg(araddr) || is_buf(araddr);

  // ****************************
  // bus slave
  // ****************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= txdl_pkg::RESP_OKAY;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= awaddr;
        aw_got_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (w_hs) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
        w_got_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? txdl_pkg::RESP_OKAY : txdl_pkg::RESP_DECERR;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= txdl_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? txdl_pkg::RESP_OKAY : txdl_pkg::RESP_DECERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ****************************
  // serializer step decode
  // ****************************
  wire st_idle = (state_ff == txdl_pkg::ST_IDLE);
  wire st_data = (state_ff == txdl_pkg::ST_DATA);
  wire st_fcs = (state_ff == txdl_pkg::ST_FCS_LO) || (state_ff == txdl_pkg::ST_FCS_HI);
  wire close_head = (state_ff == txdl_pkg::ST_CLOSE) && (bits_ff == txdl_pkg::OCTET_BITS);
  wire stuff_now = run_msg_ff && (ones_ff == txdl_pkg::STUFF_RUN) && (st_data || st_fcs || close_head);
  wire step = dl_bit_req && !st_idle;
  wire shift = step && !stuff_now;
  wire last_bit = shift && (bits_ff == 4'h1);
  wire [CW-1:0] idx_inc = idx_ff + 7'h01;
  wire [CW-1:0] rep_inc = rep_ff + 7'h01;
  wire msg_end = (idx_inc == run_count_ff);
  wire rep_end = (idx_inc == txdl_pkg::REP_OCTETS);
  wire reps_done = (run_count_ff != COUNT_ZERO) && (rep_inc == run_count_ff);
  wire [CW-1:0] nxt_idx = (!run_msg_ff && rep_end) ? COUNT_ZERO : idx_inc;
  wire other_pend = pend_ff[~cur_buf_ff];

  // pick a queued buffer, alternating when both wait
  wire start = st_idle && (pend_ff != 2'b00);
  wire start_buf = (pend_ff == 2'b11) ? ~last_buf_ff : pend_ff[1];
  wire start_open = message_oriented_mode_ff;
  assign fetch_buf = start ? start_buf : cur_buf_ff;
  assign fetch_idx = start ? COUNT_ZERO : (st_data ? nxt_idx : idx_ff);

  logic [15:0] crc_nxt;
  check_gen u_check (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(start),
    .bit_en(shift && st_data && run_msg_ff),
    .bit_in(sh_ff[0]),
    .crc_nxt(crc_nxt)
  );

  // next state and the byte that follows the current one
  logic [7:0] nxt_byte;
  logic finish, finish_eot;
  wire to_fcs_or_close_fcs = run_fcs_ff;
  always_comb begin
    nxt_state = state_ff;
    nxt_byte = txdl_pkg::FLAG_OCTET;
    finish = 1'b0;
    finish_eot = 1'b0;
    case (state_ff)
      txdl_pkg::ST_OPEN: begin
        if (run_count_ff == COUNT_ZERO) begin
          nxt_state = to_fcs_or_close_fcs ? txdl_pkg::ST_FCS_LO : txdl_pkg::ST_CLOSE;
          nxt_byte = to_fcs_or_close_fcs ? ~crc_nxt[7:0] : txdl_pkg::FLAG_OCTET;
        end else begin
          nxt_state = txdl_pkg::ST_DATA;
          nxt_byte = octet;
        end
      end
      txdl_pkg::ST_DATA: begin
        if (run_msg_ff && msg_end) begin
          nxt_state = run_fcs_ff ? txdl_pkg::ST_FCS_LO : txdl_pkg::ST_CLOSE;
          nxt_byte = run_fcs_ff ? ~crc_nxt[7:0] : txdl_pkg::FLAG_OCTET;
        end else if (!run_msg_ff && rep_end && (reps_done || other_pend)) begin
          nxt_state = txdl_pkg::ST_IDLE;
          finish = 1'b1;
          finish_eot = reps_done;
        end else begin
          nxt_byte = octet;
        end
      end
      txdl_pkg::ST_FCS_LO: begin
        nxt_state = txdl_pkg::ST_FCS_HI;
        nxt_byte = fcs_hi_ff;
      end
      txdl_pkg::ST_FCS_HI: begin
        nxt_state = txdl_pkg::ST_CLOSE;
      end
      txdl_pkg::ST_CLOSE: begin
        nxt_state = txdl_pkg::ST_IDLE;
        finish = 1'b1;
      end
      default: begin
        nxt_state = txdl_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************
  // software controls and buffer ownership
  // ****************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_msg_count_ff <= COUNT_RESET_C;
      message_oriented_mode_ff <= 1'b0;
      tx_check_append_enable_ff <= 1'b0;
      eot_sticky_ff <= 1'b0;
      pend_ff <= 2'b00;
    end else begin
      if (wr_count) begin
        tx_msg_count_ff <= wdata_ff[CW-1:0];
      end
      if (wr_ctrl) begin
        message_oriented_mode_ff <= wdata_ff[txdl_pkg::CTRL_MODE_BIT];
        tx_check_append_enable_ff <= wdata_ff[txdl_pkg::CTRL_FCS_BIT];
      end
      // sticky set wins over a write-one clear
      eot_sticky_ff <= (eot_sticky_ff && !(wr_stat && wdata_ff[txdl_pkg::STAT_EOT_BIT])) ||
                       (last_bit && finish_eot);
      for (int b = 0; b < 2; b++) begin
        pend_ff[b] <= (pend_ff[b] && !(last_bit && finish && (cur_buf_ff == b[0]))) ||
                      (wr_count && (sel_wr_bit == b[0]));
      end
    end
  end

  // ****************************
  // serial sender
  // ****************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= txdl_pkg::ST_IDLE;
      cur_buf_ff <= 1'b0;
      last_buf_ff <= 1'b1;
      run_msg_ff <= 1'b0;
      run_fcs_ff <= 1'b0;
      run_count_ff <= COUNT_ZERO;
      idx_ff <= COUNT_ZERO;
      rep_ff <= COUNT_ZERO;
      sh_ff <= 8'h00;
      fcs_hi_ff <= 8'h00;
      bits_ff <= 4'h0;
      ones_ff <= 3'h0;
      dl_bit_ff <= 1'b1;
      dl_active_ff <= 1'b0;
      eot_ff <= 1'b0;
    end else begin
      eot_ff <= last_bit && finish_eot;
      dl_active_ff <= !st_idle;
      if (start) begin
        state_ff <= start_open ? txdl_pkg::ST_OPEN : txdl_pkg::ST_DATA;
        cur_buf_ff <= start_buf;
        last_buf_ff <= start_buf;
        run_msg_ff <= message_oriented_mode_ff;
        run_fcs_ff <= message_oriented_mode_ff && tx_check_append_enable_ff;
        run_count_ff <= tx_msg_count_ff;
        idx_ff <= COUNT_ZERO;
        rep_ff <= COUNT_ZERO;
        bits_ff <= txdl_pkg::OCTET_BITS;
        ones_ff <= 3'h0;
        sh_ff <= start_open ? txdl_pkg::FLAG_OCTET : octet;
      end else if (step && stuff_now) begin
        dl_bit_ff <= 1'b0;
        ones_ff <= 3'h0;
      end else if (shift) begin
        dl_bit_ff <= sh_ff[0];
        ones_ff <= sh_ff[0] ? ones_ff + 3'h1 : 3'h0;
        sh_ff <= {1'b0, sh_ff[7:1]};
        bits_ff <= bits_ff - 4'h1;
        if (last_bit) begin
          state_ff <= nxt_state;
          sh_ff <= nxt_byte;
          bits_ff <= txdl_pkg::OCTET_BITS;
          if (st_data) begin
            idx_ff <= nxt_idx;
            rep_ff <= (!run_msg_ff && rep_end) ? rep_inc : rep_ff;
          end
          if (nxt_state == txdl_pkg::ST_FCS_LO) begin
            fcs_hi_ff <= ~crc_nxt[15:8];
          end
        end
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign dl_bit = dl_bit_ff;
  assign dl_active = dl_active_ff;
  assign tx_end_of_transfer = eot_ff;
endmodule : tx_datalink_msg_buffer_count

/* File: test/txdl_sva.sv */
// checker: register bus and link timing assertions for the transmit data-link block
`timescale 1ns/1ps
module txdl_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [txdl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [txdl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic dl_bit_req,
  input wire logic dl_bit,
  input wire logic dl_active,
  input wire logic tx_end_of_transfer
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************
  // address decode
  // ****************************
  wire logic wr_mapped = (awaddr == txdl_pkg::ADDR_CTRL) || (awaddr == txdl_pkg::ADDR_COUNT) ||
    (awaddr == txdl_pkg::ADDR_STATUS) || (awaddr[11:9] == 3'h3);
  wire logic rd_mapped = (araddr == txdl_pkg::ADDR_CTRL) || (araddr == txdl_pkg::ADDR_COUNT) ||
    (araddr == txdl_pkg::ADDR_STATUS) || (araddr[11:9] == 3'h3);
  wire logic wr_both = awvalid && awready && wvalid && wready;
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  // ****************************
  // assertions
  // ****************************
  a_write_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response missing after address and data");
  a_read_answer: assert property (rd_taken |=> rvalid)
    else $error("read response missing after address");
  a_bresp_unmapped: assert property (wr_both && !wr_mapped |-> ##2 bresp == txdl_pkg::RESP_DECERR)
    else $error("unmapped write not refused");
  a_bresp_mapped: assert property (wr_both && wr_mapped |-> ##2 bresp == txdl_pkg::RESP_OKAY)
    else $error("mapped write refused");
  a_rresp_unmapped: assert property (arvalid && arready && !rd_mapped |=> rresp == txdl_pkg::RESP_DECERR)
    else $error("unmapped read not refused");
  a_rresp_mapped: assert property (arvalid && arready && rd_mapped |=> rresp == txdl_pkg::RESP_OKAY)
    else $error("mapped read refused");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before accept");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before accept");
  a_eot_single: assert property (tx_end_of_transfer |=> !tx_end_of_transfer)
    else $error("end of transfer longer than one cycle");
  a_eot_in_run: assert property (tx_end_of_transfer |-> $past(dl_active))
    else $error("end of transfer without a transmission");
  a_eot_stops: assert property (tx_end_of_transfer |-> ##[0:3] !dl_active)
    else $error("transmission goes on after end of transfer");
  a_bit_holds: assert property (!dl_bit_req |=> $stable(dl_bit))
    else $error("link bit changed without a request");
endmodule : txdl_sva

/* File: test/link_sink.sv */
// far-side model: link bit requester and capture log
`timescale 1ns/1ps
module link_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic clear,
  input wire logic dl_bit,
  input wire logic dl_active,
  output logic dl_bit_req,
  output logic [7:0] n_bits,
  output logic [255:0] bits
);
  logic req_d_ff;
  wire logic nxt_req = dl_active && !(slow && dl_bit_req);
  wire logic log_full = (n_bits == 8'hFF);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dl_bit_req <= 1'b0;
      req_d_ff <= 1'b0;
    end else begin
      dl_bit_req <= nxt_req;
      req_d_ff <= dl_bit_req;
    end
  end
  // log one link bit the cycle after each request the sender took
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      n_bits <= 8'h00;
    end else if (req_d_ff && dl_active && !log_full) begin
      bits[n_bits] <= dl_bit;
      n_bits <= n_bits + 8'h01;
    end
  end
endmodule : link_sink

/* File: test/tx_datalink_msg_buffer_count_test.sv */
// testbench: register access, buffer select and message transmission
`timescale 1ns/1ps
module tx_datalink_msg_buffer_count_test;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, clear;
  logic awready, wready, bvalid, arready, rvalid, dl_bit_req, dl_bit, dl_active, tx_end_of_transfer;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] n_bits;
  logic [255:0] bits;
  int miscompares = 0;
  int n_checks = 0;
  int n_eot = 0;
  typedef struct packed {logic [11:0] addr; logic [7:0] data; logic [1:0] resp;} row_type;
  row_type rows [4];
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  tx_datalink_msg_buffer_count uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .dl_bit_req, .dl_bit, .dl_active, .tx_end_of_transfer);
  link_sink sink (.aclk, .aresetn, .slow, .clear, .dl_bit, .dl_active, .dl_bit_req, .n_bits, .bits);
  always @(posedge aclk) if (tx_end_of_transfer === 1'b1) n_eot <= n_eot + 1;
  // ****************************
  // tasks
  // ****************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic guard(input int k);
    if (k > 4000) begin
      miscompares++;
      finish_test();
    end
  endtask : guard
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
      guard(++k);
    end
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
      guard(++k);
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic send(input logic sel, input logic [6:0] n);
    @(posedge aclk);
    clear <= 1'b1;
    @(posedge aclk);
    clear <= 1'b0;
    wr(txdl_pkg::ADDR_COUNT, {24'h000000, sel, n}, resp);
    check("count write resp", txdl_pkg::RESP_OKAY, resp);
  endtask : send
  // which 0 waits for end of transfer, 1 for the line to go idle
  task automatic wait_sig(input int which);
    int k = 0;
    if (which == 1) repeat (4) @(posedge aclk);
    while (!(which == 0 ? tx_end_of_transfer === 1'b1 : dl_active === 1'b0)) begin
      @(posedge aclk);
      guard(++k);
    end
    repeat (4) @(posedge aclk);
  endtask : wait_sig
  // ****************************
  // main sequence
  // ****************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, slow, clear} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    rows[0] = '{txdl_pkg::ADDR_CTRL, 8'h00, txdl_pkg::RESP_OKAY};
    rows[1] = '{txdl_pkg::ADDR_COUNT, 8'h00, txdl_pkg::RESP_OKAY};
    rows[2] = '{txdl_pkg::ADDR_STATUS, 8'h00, txdl_pkg::RESP_OKAY};
    rows[3] = '{12'h15C, 8'h00, txdl_pkg::RESP_DECERR};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].addr, data, resp);
      check("read resp", rows[i].resp, resp);
      if (rows[i].resp === txdl_pkg::RESP_OKAY) check("reset value", rows[i].data, data & 32'hFF);
    end
    wr(12'h15C, 32'h000000FF, resp);
    check("unmapped write resp", txdl_pkg::RESP_DECERR, resp);
    wr({txdl_pkg::PAGE_BUF0, 8'h00}, 32'h0000C35A, resp);
    send(1'b0, 7'h02);
    rd(txdl_pkg::ADDR_COUNT, data, resp);
    check("free buffer while sending 0", 32'h1, data[7]);
    wait_sig(0);
    check("repeated bits", 32'hC35AC35A, bits[31:0]);
    check("stopped after count", 32'h1, n_bits >= 32 && n_bits <= 34);
    check("eot count", 32'h1, n_eot);
    check("idle after eot", 32'h0, dl_active);
    rd(txdl_pkg::ADDR_COUNT, data, resp);
    check("free buffer after send", 32'h0, data[7]);
    rd(txdl_pkg::ADDR_STATUS, data, resp);
    check("eot status", 32'h1, data[txdl_pkg::STAT_EOT_BIT]);
    wr({txdl_pkg::PAGE_BUF1, 8'h00}, 32'h00003CA5, resp);
    slow <= 1'b1;
    send(1'b1, 7'h00);
    repeat (300) @(posedge aclk);
    check("buffer 1 bits", 32'h3CA53CA5, bits[31:0]);
    check("no eot forever", 32'h1, n_eot);
    check("still running", 32'h1, dl_active);
    rd(txdl_pkg::ADDR_COUNT, data, resp);
    check("free buffer while sending 1", 32'h0, data[7]);
    send(1'b0, 7'h01);
    wait_sig(0);
    check("eot only for counted run", 32'h2, n_eot);
    slow <= 1'b0;
    wait_sig(1);
    wr(txdl_pkg::ADDR_CTRL, 32'h00000001, resp);
    wr({txdl_pkg::PAGE_BUF0, 8'h00}, 32'h00030201, resp);
    send(1'b0, 7'h03);
    wait_sig(1);
    check("frame head", 32'h0302017E, bits[31:0]);
    check("frame tail", 32'h7E030201, bits[39:8]);
    check("frame length", 32'h1, n_bits >= 40 && n_bits <= 41);
    wr(txdl_pkg::ADDR_CTRL, 32'h00000003, resp);
    send(1'b0, 7'h03);
    wait_sig(1);
    check("checked frame head", 32'h0302017E, bits[31:0]);
    check("checked frame length", 32'h1, n_bits >= 56 && n_bits <= 63);
    finish_test();
  end
endmodule : tx_datalink_msg_buffer_count_test
bind tx_datalink_msg_buffer_count txdl_sva chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .dl_bit_req, .dl_bit, .dl_active, .tx_end_of_transfer);
